// >>> ssc_status_top.sv
// Status word, command decode and checksummed two-wire link of the sensor
`timescale 1ns/1ns
`include "ssc_consts.svh"

module ssc_status_top import ssc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h40,
	parameter logic [15:0] CMD_STATUS_READ = 16'hf300,
	parameter logic [15:0] CMD_SOFT_RESET = 16'h30a0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_clk,
	input wire logic sda_in,
	input wire logic rh_alert_set,
	input wire logic t_alert_set,
	input wire logic supply_fail,
	output logic sda_out,
	output logic sda_oe,
	output logic heater_on,
	output logic cmd_valid,
	output logic [15:0] cmd_code,
	output logic [15:0] status_word
);

	// ----------------------------------------------------------------
	// Link domain: bit receiver on the link clock
	// ----------------------------------------------------------------
	logic frame_clr_reg;
	logic link_clr;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	ssc_byte_t rx_byte_reg;
	logic rx_tgl_reg;
	logic ack_bit_reg;
	logic ack_tgl_reg;

	// Counter is held clear from START/STOP until the first low phase,
	// so its release never races a rising link clock edge
	assign link_clr = reset | frame_clr_reg;

	always_ff @(posedge scl_clk or posedge link_clr) begin
		if (link_clr) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else begin
			shift_reg <= {shift_reg[6:0], sda_in};
			bit_cnt_reg <= (bit_cnt_reg == `SSC_BITS_PER_BYTE) ? 4'h0 :
				bit_cnt_reg + 4'h1;
		end
	end

	// Toggles are not cleared by framing, otherwise a clear looks like an event
	always_ff @(posedge scl_clk or posedge reset) begin
		if (reset) begin
			rx_byte_reg <= 8'h00;
			rx_tgl_reg <= 1'b0;
			ack_bit_reg <= 1'b1;
			ack_tgl_reg <= 1'b0;
		end else if (bit_cnt_reg == 4'h7) begin
			rx_byte_reg <= {shift_reg[6:0], sda_in};
			rx_tgl_reg <= ~rx_tgl_reg;
		end else if (bit_cnt_reg == `SSC_BITS_PER_BYTE) begin
			ack_bit_reg <= sda_in;
			ack_tgl_reg <= ~ack_tgl_reg;
		end
	end

	// ----------------------------------------------------------------
	// Synchronisers into the system clock
	// ----------------------------------------------------------------
	// Order: scl, sda, byte toggle, ack toggle, supply failure
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] prev_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= 5'h18;
			sync2_reg <= 5'h18;
			prev_reg <= 5'h18;
		end else begin
			sync1_reg <= {scl_clk, sda_in, rx_tgl_reg, ack_tgl_reg,
				supply_fail};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	wire scl_s = sync2_reg[4];
	wire sda_s = sync2_reg[3];
	wire scl_p = prev_reg[4];
	wire sda_p = prev_reg[3];
	wire start_det = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
	wire scl_fall = scl_p & ~scl_s;
	wire rx_evt = sync2_reg[2] ^ prev_reg[2];
	wire ack_evt = sync2_reg[1] ^ prev_reg[1];
	wire supply_bad = sync2_reg[0];

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	logic alert_reg;
	logic heater_reg;
	logic rh_alert_reg;
	logic t_alert_reg;
	logic reset_seen_reg;
	logic cmd_fail_reg;
	logic wr_crc_reg;

	ssc_state_e state_reg;
	logic [7:0] cmd_hi_reg;
	logic [1:0] widx_reg;
	ssc_word_t wword_reg;
	logic read_armed_reg;

	wire ssc_word_t cmd_rx = {cmd_hi_reg, rx_byte_reg};
	wire byte_in = rx_evt & (state_reg != SSC_READ);
	wire cmd_done = byte_in & (state_reg == SSC_CMD_LO);
	wire is_clear = cmd_rx == `SSC_CMD_CLEAR;
	wire is_heat_on = cmd_rx == `SSC_CMD_HEAT_ON;
	wire is_heat_off = cmd_rx == `SSC_CMD_HEAT_OFF;
	wire is_status = cmd_rx == CMD_STATUS_READ;
	wire is_soft = cmd_rx == CMD_SOFT_RESET;
	wire cmd_known = is_clear | is_heat_on | is_heat_off | is_status |
		is_soft;
	wire do_clear = cmd_done & is_clear;
	wire do_soft = cmd_done & is_soft;
	wire crc_done = byte_in & (state_reg == SSC_WDATA) & (widx_reg == 2'h2);

	// Hardware sets win over the clear command in the same cycle
	wire rh_next = (rh_alert_reg & ~do_clear) | rh_alert_set;
	wire t_next = (t_alert_reg & ~do_clear) | t_alert_set;
	wire alert_next = (alert_reg & ~do_clear) | rh_alert_set |
		t_alert_set;
	wire reset_next = (reset_seen_reg & ~do_clear) | do_soft |
		supply_bad;
	wire heater_next = do_soft ? 1'b0 :
		(cmd_done & is_heat_on) ? 1'b1 :
		(cmd_done & is_heat_off) ? 1'b0 : heater_reg;

	// Write word checksum, covering only the two bytes just received
	ssc_byte_t wr_crc_calc;
	ssc_crc8 u_wr_crc (
		.word(wword_reg),
		.crc(wr_crc_calc)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			alert_reg <= `SSC_RST_ALERT;
			heater_reg <= `SSC_RST_HEATER;
			rh_alert_reg <= `SSC_RST_TRACK;
			t_alert_reg <= `SSC_RST_TRACK;
			reset_seen_reg <= `SSC_RST_RESET;
			cmd_fail_reg <= `SSC_RST_CMD_FAIL;
			wr_crc_reg <= `SSC_RST_WR_CRC;
		end else begin
			alert_reg <= alert_next;
			heater_reg <= heater_next;
			rh_alert_reg <= rh_next;
			t_alert_reg <= t_next;
			reset_seen_reg <= reset_next;
			if (cmd_done) begin
				cmd_fail_reg <= ~cmd_known;
			end
			if (crc_done) begin
				wr_crc_reg <= rx_byte_reg != wr_crc_calc;
			end
		end
	end

	// Reserved bits 14, 12, 9:5 and 3:2 are driven zero
	wire ssc_word_t status_now = {alert_reg, 1'b0, heater_reg, 1'b0,
		rh_alert_reg, t_alert_reg, 5'h00, reset_seen_reg, 2'h0,
		cmd_fail_reg, wr_crc_reg};

	// ----------------------------------------------------------------
	// Transfer sequencing
	// ----------------------------------------------------------------
	wire addr_hit = rx_byte_reg[7:1] == DEV_ADDR;
	wire addr_rd = rx_byte_reg[0];
	wire ack_accept = byte_in & ((state_reg == SSC_ADDR) ?
		(addr_hit & (~addr_rd | read_armed_reg)) :
		(state_reg != SSC_IDLE));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= SSC_IDLE;
			cmd_hi_reg <= 8'h00;
			widx_reg <= 2'h0;
			wword_reg <= 16'h0000;
			read_armed_reg <= 1'b0;
		end else if (start_det) begin
			state_reg <= SSC_ADDR;
		end else if (stop_det) begin
			state_reg <= SSC_IDLE;
		end else if (byte_in) begin
			case (state_reg)
			SSC_ADDR: begin
				if (!addr_hit) begin
					state_reg <= SSC_IDLE;
				end else if (!addr_rd) begin
					state_reg <= SSC_CMD_HI;
				end else if (read_armed_reg) begin
					state_reg <= SSC_READ;
				end else begin
					state_reg <= SSC_IDLE;
				end
			end
			SSC_CMD_HI: begin
				cmd_hi_reg <= rx_byte_reg;
				state_reg <= SSC_CMD_LO;
			end
			SSC_CMD_LO: begin
				read_armed_reg <= is_status;
				widx_reg <= 2'h0;
				state_reg <= SSC_WDATA;
			end
			SSC_WDATA: begin
				case (widx_reg)
				2'h0: wword_reg[15:8] <= rx_byte_reg;
				2'h1: wword_reg[7:0] <= rx_byte_reg;
				default: wword_reg <= wword_reg;
				endcase
				widx_reg <= (widx_reg == 2'h2) ? 2'h0 : widx_reg + 2'h1;
			end
			default: state_reg <= state_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data: snapshot of the status word and its checksum
	// ----------------------------------------------------------------
	ssc_word_t snap_reg;
	ssc_byte_t snap_crc;
	ssc_crc8 u_rd_crc (
		.word(snap_reg),
		.crc(snap_crc)
	);

	logic ack_pend_reg;
	logic tx_active_reg;
	logic [3:0] tx_bit_reg;
	logic [1:0] tx_idx_reg;

	// Word MSB first, then its CRC, then the line is left released
	wire ssc_byte_t tx_byte = (tx_idx_reg == 2'h0) ? snap_reg[15:8] :
		(tx_idx_reg == 2'h1) ? snap_reg[7:0] :
		(tx_idx_reg == 2'h2) ? snap_crc : `SSC_IDLE_BYTE;
	wire tx_bit_val = tx_byte[3'(4'h7 - tx_bit_reg)];
	wire rd_accept = byte_in & (state_reg == SSC_ADDR) & addr_hit & addr_rd &
		read_armed_reg;

	// The line is only driven after a falling link clock; START or STOP releases it while high
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			snap_reg <= 16'h0000;
			ack_pend_reg <= 1'b0;
			tx_active_reg <= 1'b0;
			tx_bit_reg <= 4'h0;
			tx_idx_reg <= 2'h0;
			sda_oe <= 1'b0;
		end else begin
			if (start_det || stop_det) begin
				tx_active_reg <= 1'b0;
				ack_pend_reg <= 1'b0;
				sda_oe <= 1'b0;
			end else if (ack_accept) begin
				ack_pend_reg <= 1'b1;
			end
			if (rd_accept) begin
				snap_reg <= status_now;
				tx_active_reg <= 1'b1;
				tx_idx_reg <= 2'h0;
			end
			// A master NACK ends the read so it can issue STOP
			if (ack_evt && state_reg == SSC_READ && ack_bit_reg) begin
				tx_active_reg <= 1'b0;
			end
			if (scl_fall && !start_det && !stop_det) begin
				if (ack_pend_reg) begin
					sda_oe <= 1'b1;
					ack_pend_reg <= 1'b0;
					tx_bit_reg <= 4'h0;
				end else if (tx_active_reg &&
					tx_bit_reg != `SSC_BITS_PER_BYTE) begin
					sda_oe <= ~tx_bit_val;
					tx_bit_reg <= tx_bit_reg + 4'h1;
				end else begin
					sda_oe <= 1'b0;
					if (tx_active_reg) begin
						tx_bit_reg <= 4'h0;
						if (tx_idx_reg != `SSC_READ_BYTES) begin
							tx_idx_reg <= tx_idx_reg + 2'h1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Framing hold and registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frame_clr_reg <= 1'b1;
			sda_out <= 1'b0;
			heater_on <= `SSC_RST_HEATER;
			cmd_valid <= 1'b0;
			cmd_code <= 16'h0000;
			status_word <= 16'h0000;
		end else begin
			if (start_det || stop_det) begin
				frame_clr_reg <= 1'b1;
			end else if (scl_fall) begin
				frame_clr_reg <= 1'b0;
			end
			sda_out <= 1'b0;
			heater_on <= heater_reg;
			cmd_valid <= cmd_done & cmd_known;
			if (cmd_done) begin
				cmd_code <= cmd_rx;
			end
			status_word <= status_now;
		end
	end

endmodule

// >>> ssc_consts.svh
// Constants of the sensor status word, its commands and the checksum
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define SSC_BIT_ALERT 15
`define SSC_BIT_HEATER 13
`define SSC_BIT_RH_ALERT 11
`define SSC_BIT_T_ALERT 10
`define SSC_BIT_RESET 4
`define SSC_BIT_CMD_FAIL 1
`define SSC_BIT_WR_CRC 0

// ----------------------------------------------------------------
// Reset values of the flags
// ----------------------------------------------------------------
`define SSC_RST_ALERT 1'b0
`define SSC_RST_HEATER 1'b0
`define SSC_RST_TRACK 1'b0
`define SSC_RST_RESET 1'b1
`define SSC_RST_CMD_FAIL 1'b0
`define SSC_RST_WR_CRC 1'b0

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SSC_CMD_CLEAR 16'h3041
`define SSC_CMD_HEAT_ON 16'h306d
`define SSC_CMD_HEAT_OFF 16'h3066

// ----------------------------------------------------------------
// Checksum
// ----------------------------------------------------------------
`define SSC_CRC_POLY 8'h31
`define SSC_CRC_INIT 8'hff
`define SSC_CRC_XOROUT 8'h00

// ----------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------
`define SSC_BITS_PER_BYTE 4'h8
`define SSC_READ_BYTES 2'h3
`define SSC_IDLE_BYTE 8'hff

`endif

// >>> ssc_pkg.sv
// Types shared by the status and checksum block
package ssc_pkg;

	typedef enum logic [2:0] {
		SSC_IDLE,
		SSC_ADDR,
		SSC_CMD_HI,
		SSC_CMD_LO,
		SSC_WDATA,
		SSC_READ
	} ssc_state_e;

	typedef logic [15:0] ssc_word_t;
	typedef logic [7:0] ssc_byte_t;

endpackage

// >>> ssc_crc8.sv
// Checksum of one 16-bit data word
`timescale 1ns/1ns
`include "ssc_consts.svh"

module ssc_crc8 import ssc_pkg::*; (
	input wire ssc_word_t word,
	output ssc_byte_t crc
);

	function automatic ssc_byte_t ssc_crc_calc(input ssc_word_t w);
		ssc_byte_t c;
		logic fb;
		c = `SSC_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			fb = c[7] ^ w[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ `SSC_CRC_POLY;
			end
		end
		return c ^ `SSC_CRC_XOROUT;
	endfunction

	assign crc = ssc_crc_calc(word);

endmodule

// >>> ssc_master_model.sv
// Two-wire master model that issues commands to the sensor block
`timescale 1ns/1ns
module ssc_master_model #(
	parameter int H = 320,
	parameter logic [6:0] ADDR = 7'h40
) (
	input wire logic sda,
	output logic scl,
	output logic m_oe
);
	// SCL stands high and SDA released between frames
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end

	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction

	// Data moves a quarter slot after SCL falls, never while high
	task automatic bitx(input logic b, output logic r);
		#80 m_oe = !b;
		#(H - 80) scl = 1'b1;
		#H r = sda;
		scl = 1'b0;
	endtask

	task automatic start;
		#1 m_oe = 1'b0;
		scl = 1'b1;
		#H m_oe = 1'b1;
		#H scl = 1'b0;
	endtask

	task automatic stop;
		#80 m_oe = 1'b1;
		#(H - 80) scl = 1'b1;
		#H m_oe = 1'b0;
		#H;
	endtask

	task automatic wbyte(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ok = ok && !r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(last, r);
	endtask

	// Word and its checksum follow the command when n is set
	task automatic write(input logic [15:0] c, input int n,
			input logic [15:0] w, input logic [7:0] k, output logic ok);
		ok = 1'b1;
		start();
		wbyte({ADDR, 1'b0}, ok);
		wbyte(c[15:8], ok);
		wbyte(c[7:0], ok);
		if (n != 0) begin
			wbyte(w[15:8], ok);
			wbyte(w[7:0], ok);
			wbyte(k, ok);
		end
		stop();
	endtask

	// Master NACKs the checksum byte to end the read
	task automatic read3(output logic [23:0] d, output logic ok);
		ok = 1'b1;
		start();
		wbyte({ADDR, 1'b1}, ok);
		rbyte(1'b0, d[23:16]);
		rbyte(1'b0, d[15:8]);
		rbyte(1'b1, d[7:0]);
		stop();
	endtask
endmodule

// >>> ssc_status_top_props.sv
// Concurrent checks on the status and checksum block ports
`timescale 1ns/1ns
`include "ssc_consts.svh"
module ssc_status_top_props #(
	parameter logic [15:0] CMD_SOFT_RESET = 16'h30a0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_clk,
	input wire logic sda_in,
	input wire logic rh_alert_set,
	input wire logic t_alert_set,
	input wire logic supply_fail,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic heater_on,
	input wire logic cmd_valid,
	input wire logic [15:0] cmd_code,
	input wire logic [15:0] status_word
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_RSVD: assert property ((status_word & 16'h500c) == 16'h0000)
		else $error("reserved status bits not zero");
	AST_RH_ALERT: assert property (rh_alert_set |->
		##2 (status_word[15] && status_word[11]))
		else $error("humidity alert not flagged");
	AST_T_ALERT: assert property (t_alert_set |->
		##2 (status_word[15] && status_word[10]))
		else $error("temperature alert not flagged");
	AST_HEAT_BIT: assert property (heater_on == status_word[13])
		else $error("heater bit and heater output disagree");
	AST_CLEAR: assert property (cmd_valid && cmd_code == `SSC_CMD_CLEAR &&
		!rh_alert_set && !t_alert_set && !supply_fail |->
		##[1:2] (status_word & 16'h8c10) == 16'h0000)
		else $error("clear command left flags set");
	AST_HEAT_ON: assert property (cmd_valid && cmd_code == `SSC_CMD_HEAT_ON
		|-> ##[1:3] heater_on)
		else $error("heater not switched on");
	AST_HEAT_OFF: assert property (cmd_valid &&
		cmd_code == `SSC_CMD_HEAT_OFF |-> ##[1:3] !heater_on)
		else $error("heater not switched off");
	AST_SOFT_RST: assert property (cmd_valid && cmd_code == CMD_SOFT_RESET
		|-> ##[1:2] status_word[4])
		else $error("soft reset not flagged");
	AST_CMD_OK: assert property (cmd_valid |-> ##[1:2] !status_word[1])
		else $error("command status not cleared on success");
	AST_SUPPLY: assert property (supply_fail [*6] |-> status_word[4])
		else $error("supply failure not flagged");
endmodule

bind ssc_status_top ssc_status_top_props #(
	.CMD_SOFT_RESET(CMD_SOFT_RESET)
) ssc_status_top_props_i (
	.clk(clk), .reset(reset), .scl_clk(scl_clk), .sda_in(sda_in),
	.rh_alert_set(rh_alert_set), .t_alert_set(t_alert_set),
	.supply_fail(supply_fail), .sda_out(sda_out), .sda_oe(sda_oe),
	.heater_on(heater_on), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.status_word(status_word)
);

// >>> ssc_status_top_bench.sv
// Self-checking bench for the status word and checksum block
`timescale 1ns/1ns
module ssc_status_top_bench import ssc_pkg::*; ;
	logic clk = 1'b0;
	logic reset;
	logic rh = 1'b0;
	logic ta = 1'b0;
	logic sf = 1'b0;
	logic sda, scl, m_oe, sda_out, sda_oe, heater_on, cmd_valid;
	logic [15:0] cmd_code, status_word;
	int num_errors = 0;
	int total_checks = 0;
	int nv = 0;
	logic [23:0] rd_d;
	logic rd_ok;

	always #5 clk = ~clk;
	// Pulse count of the one-cycle command strobe, read where settled
	always @(negedge clk) begin
		if (cmd_valid === 1'b1) begin
			nv++;
		end
	end
	// Open-drain wire: low if any party pulls
	assign sda = !(m_oe || sda_oe);

	ssc_status_top #(.DEV_ADDR(7'h40), .CMD_STATUS_READ(16'hf300),
		.CMD_SOFT_RESET(16'h30a0)) ssc_status_top_i (
		.clk(clk), .reset(reset), .scl_clk(scl), .sda_in(sda),
		.rh_alert_set(rh), .t_alert_set(ta), .supply_fail(sf),
		.sda_out(sda_out), .sda_oe(sda_oe), .heater_on(heater_on),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.status_word(status_word));

	// SCL slowed well below the clk-domain synchroniser limit
	ssc_master_model #(.H(320), .ADDR(7'h40)) ssc_master_model_i (
		.sda(sda), .scl(scl), .m_oe(m_oe));

	task automatic chk(input string n, input ssc_word_t e, input ssc_word_t g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Commands this block executes; anything else must fail
	function automatic logic known(input ssc_word_t c);
		return c == 16'h3041 || c == 16'h306d || c == 16'h3066 ||
			c == 16'hf300 || c == 16'h30a0;
	endfunction

	task automatic cmd(input ssc_word_t c, input int n, input ssc_word_t w,
			input ssc_byte_t k);
		logic ok;
		int v0;
		@(posedge clk);
		v0 = nv;
		ssc_master_model_i.write(c, n, w, k, ok);
		chk("write ack", 16'h0001, {15'h0, ok});
		wt(8);
		chk("cmd code", c, cmd_code);
		chk("cmd valid", {15'h0, known(c)}, 16'(nv - v0));
	endtask

	task automatic rd(input ssc_word_t e);
		logic [23:0] d;
		logic ok;
		cmd(16'hf300, 0, 16'h0, 8'h0);
		@(posedge clk);
		ssc_master_model_i.read3(d, ok);
		chk("read ack", 16'h0001, {15'h0, ok});
		chk("read word", e, d[23:8]);
		chk("read crc", {8'h0, ssc_master_model_i.crc8(e)}, {8'h0, d[7:0]});
		wt(8);
		chk("line released", 16'h0000, {15'h0, sda_oe});
	endtask

	task automatic alert(input logic r);
		@(posedge clk);
		rh <= r;
		ta <= !r;
		@(posedge clk);
		rh <= 1'b0;
		ta <= 1'b0;
		wt(3);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wt(4);
		chk("after reset", 16'h0010, status_word);
		chk("data out low", 16'h0000, {15'h0, sda_out});
		chk("heater reset", 16'h0000, {15'h0, heater_on});
		rd(16'h0010);
		$display("test reset done");
		cmd(16'h306d, 0, 16'h0, 8'h0);
		chk("heater on", 16'h2010, status_word);
		chk("heater pin", 16'h0001, {15'h0, heater_on});
		rd(16'h2010);
		cmd(16'h3066, 0, 16'h0, 8'h0);
		chk("heater off", 16'h0010, status_word);
		$display("test heater done");
		alert(1'b1);
		chk("rh alert", 16'h8810, status_word);
		alert(1'b0);
		chk("t alert", 16'h8c10, status_word);
		cmd(16'h3041, 0, 16'h0, 8'h0);
		chk("cleared", 16'h0000, status_word);
		cmd(16'h1234, 0, 16'h0, 8'h0);
		chk("bad cmd", 16'h0002, status_word);
		// Read header without a preceding status-read command is refused
		@(posedge clk);
		ssc_master_model_i.read3(rd_d, rd_ok);
		chk("read refused", 16'h0000, {15'h0, rd_ok});
		wt(8);
		$display("test flags done");
		cmd(16'h3041, 1, 16'hbeef, 8'h93);
		chk("bad wcrc", 16'h0001, status_word);
		cmd(16'h3041, 1, 16'hbeef, 8'h92);
		chk("good wcrc", 16'h0000, status_word);
		@(posedge clk);
		sf <= 1'b1;
		repeat (8) @(posedge clk);
		sf <= 1'b0;
		wt(4);
		chk("supply fail", 16'h0010, status_word);
		cmd(16'h3041, 0, 16'h0, 8'h0);
		cmd(16'h306d, 0, 16'h0, 8'h0);
		chk("heat again", 16'h2000, status_word);
		cmd(16'h30a0, 0, 16'h0, 8'h0);
		chk("soft reset", 16'h0010, status_word);
		$display("test checksum and reset events done");
		cmd(16'h306d, 0, 16'h0, 8'h0);
		chk("heater before reset", 16'h2010, status_word);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wt(4);
		chk("second reset", 16'h0010, status_word);
		chk("heater reset again", 16'h0000, {15'h0, heater_on});
		$display("test second reset done");
		tally_and_finish();
	end

	initial begin
		#900000;
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
